/* File: common/tick_if.sv */
/*
  Carries the divided count-source enables from the divider to the timers.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
  logic [3:0] div_tick;
  modport src(output div_tick);
  modport sink(input div_tick);
endinterface
`default_nettype wire

/* File: common/tmr_pkg.sv */
/*
  Shared constants for the multi-mode timer set: register indices,
  field positions, reset values, divider taps and mode encodings.
  Assumes a 32-bit Avalon-MM slave with byte address = 4 * index.
*/
`default_nettype none
package tmr_pkg;
  // ***************************************************************
  // register word indices
  // ***************************************************************
  localparam logic [3:0] IDX_TX_LO = 4'h0;
  localparam logic [3:0] IDX_TX_HI = 4'h1;
  localparam logic [3:0] IDX_TY_LO = 4'h2;
  localparam logic [3:0] IDX_TY_HI = 4'h3;
  localparam logic [3:0] IDX_T1 = 4'h4;
  localparam logic [3:0] IDX_TX_MODE = 4'h7;
  localparam logic [3:0] IDX_TY_MODE = 4'h8;
  localparam logic [3:0] IDX_T123_MODE = 4'h9;
  localparam logic [3:0] IDX_SMALL_TIMER_TOGGLE_PIN_CTRL = 4'hA;
  localparam logic [3:0] IDX_STATUS = 4'hB;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int XM_SRC = 2;
  localparam int XM_SPECIAL = 4;
  localparam int XM_POL = 5;
  localparam int XM_STOP = 6;
  localparam int XM_WC = 7;
  localparam int YM_SRC = 2;
  localparam int YM_OUTEN = 4;
  localparam int YM_POL = 5;
  localparam int YM_WC = 7;
  localparam int SM_WC12 = 6;
  localparam int OC_EN = 0;
  localparam int OC_SEL = 1;
  localparam int OC_POL = 2;
  localparam int ST_TX = 0;
  localparam int ST_TY = 1;
  localparam int ST_T1 = 2;
  localparam int ST_PX = 5;
  localparam int ST_PY = 6;
  // ***************************************************************
  // reset values and divider
  // ***************************************************************
  localparam logic [15:0] CNT16_RST = 16'hFFFF;
  localparam logic [7:0] CNT8_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int DIV_TAPS = 4;
  localparam int DIV_W = 6;
  localparam int DIV_FIRST = 3;
  // ***************************************************************
  // mode encodings
  // ***************************************************************
  typedef enum logic [1:0] {X_TIMER, X_PULSE, X_EVENT, X_WIDTH} x_mode_t;
  typedef enum logic [1:0] {Y_TIMER, Y_PERIOD, Y_EVENT, Y_HL} y_mode_t;
endpackage
`default_nettype wire

/* File: design/multi_mode_timer_set.sv */
/*
  Two 16-bit and three 8-bit down-counting timers behind an Avalon-MM
  slave with waitrequest. Assumes bus signals on sys_clk and pins
  asynchronous; pin drivers are resolved outside from the enables.
*/
// Function
// - X,Y 16-bit; timers 1-3 8-bit down
// - X pulse mode toggles pin per underflow
// - X polarity picks pulse start level
// - X event mode counts selected pin edge
// - X width mode counts while pin active
// - X source special clock or div 8-64
// - X write-control 1: latch only
// - X write-control 0: counter and latch
// - X pin request edge follows polarity
// - Y timer mode counts div 8-64 only
// - Y output control toggles pin per underflow
// - Y polarity picks toggle start level
// - Y period edge: request, reload, continue
// - captured pre-reload value until Y read
// - Y period edge: falling 0, rising 1
// - Y event counts edges, no toggle
// - Y HL mode reloads on both edges
// - Y write-control like X
// - shared 1,2 write-control latch only
// - toggle pin from timer 1 or 2
// - underflow after zero reloads, sets request
// - X stop bit halts all modes
`timescale 1ns/1ps
`default_nettype none
module multi_mode_timer_set (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timer_x_ext_pin_i,
  output logic timer_x_ext_pin_o,
  output logic timer_x_ext_pin_oe,
  input wire logic timer_y_ext_pin_i,
  output logic timer_y_ext_pin_o,
  output logic timer_y_ext_pin_oe,
  output logic small_timer_toggle_pin,
  input wire logic special_count_source_clock
);
  // ***************************************************************
  // pins and prescaler
  // ***************************************************************
  tick_if ticks ();
  logic x_lvl, x_rise, x_fall, y_lvl, y_rise, y_fall, sp_rise;

  tick_divider u_div (.sys_clk(sys_clk), .rst_b(rst_b), .ticks(ticks.src));
  pin_sampler u_xpin (.sys_clk(sys_clk), .rst_b(rst_b), .pin(timer_x_ext_pin_i),
    .level(x_lvl), .rise(x_rise), .fall(x_fall));
  pin_sampler u_ypin (.sys_clk(sys_clk), .rst_b(rst_b), .pin(timer_y_ext_pin_i),
    .level(y_lvl), .rise(y_rise), .fall(y_fall));
  pin_sampler u_spin (.sys_clk(sys_clk), .rst_b(rst_b),
    .pin(special_count_source_clock), .level(), .rise(sp_rise), .fall());

  // ***************************************************************
  // bus slave
  // ***************************************************************
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [3:0] idx;
  logic [7:0] wdat;
  logic wr_take, rd_fire;
  logic [7:0] xmode_ff, ymode_ff, smode_ff, octl_ff, status_ff;
  logic [7:0] wr_buf_ff, rd_buf_ff;

  assign idx = avs_address[5:2];
  assign wdat = avs_writedata[7:0];
  // writes act on the edge that sees waitrequest low
  assign wr_take = avs_write & ~wait_ff & avs_byteenable[0];
  // reads are answered one edge earlier so data stands at the take edge
  assign rd_fire = avs_read & wait_ff;

  // one wait cycle per access, then release for one cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_ff <= 1'b1;
    end else if ((avs_read | avs_write) & wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  // control registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xmode_ff <= tmr_pkg::CTRL_RST;
      ymode_ff <= tmr_pkg::CTRL_RST;
      smode_ff <= tmr_pkg::CTRL_RST;
      octl_ff <= tmr_pkg::CTRL_RST;
    end else if (wr_take) begin
      if (idx == tmr_pkg::IDX_TX_MODE) begin
        xmode_ff <= wdat;
      end else if (idx == tmr_pkg::IDX_TY_MODE) begin
        ymode_ff <= wdat;
      end else if (idx == tmr_pkg::IDX_T123_MODE) begin
        smode_ff <= wdat;
      end else if (idx == tmr_pkg::IDX_SMALL_TIMER_TOGGLE_PIN_CTRL) begin
        octl_ff <= wdat;
      end
    end
  end

  // ***************************************************************
  // mode decode and count enables
  // ***************************************************************
  tmr_pkg::x_mode_t x_mode;
  tmr_pkg::y_mode_t y_mode;
  logic x_pol, y_pol, x_src, y_src;
  logic [1:0] tick16, direct16, latchwr16, uf16, reload16;
  logic [2:0] tick8, direct8, latchwr8, uf8;
  logic [15:0] cnt16_ff [2];
  logic [15:0] latch16_ff [2];
  logic [7:0] cnt8_ff [3];
  logic [7:0] latch8_ff [3];
  logic [15:0] hold_ff, y_val;
  logic hold_valid_ff, px_req, py_req;

  assign x_mode = tmr_pkg::x_mode_t'(xmode_ff[1:0]);
  assign y_mode = tmr_pkg::y_mode_t'(ymode_ff[1:0]);
  assign x_pol = xmode_ff[tmr_pkg::XM_POL];
  assign y_pol = ymode_ff[tmr_pkg::YM_POL];
  assign x_src = xmode_ff[tmr_pkg::XM_SPECIAL] ? sp_rise :
    ticks.div_tick[xmode_ff[tmr_pkg::XM_SRC +: 2]];
  assign y_src = ticks.div_tick[ymode_ff[tmr_pkg::YM_SRC +: 2]];

  // per-mode count pulses
  always_comb begin
    tick16 = 2'b00;
    reload16 = 2'b00;
    case (x_mode)
      tmr_pkg::X_EVENT: tick16[0] = x_pol ? x_fall : x_rise;
      tmr_pkg::X_WIDTH: tick16[0] = x_src & (x_lvl == ~x_pol);
      default: tick16[0] = x_src;
    endcase
    if (xmode_ff[tmr_pkg::XM_STOP]) begin
      tick16[0] = 1'b0;
    end
    case (y_mode)
      tmr_pkg::Y_EVENT: tick16[1] = y_pol ? y_fall : y_rise;
      tmr_pkg::Y_PERIOD: begin
        tick16[1] = y_src;
        reload16[1] = y_pol ? y_rise : y_fall;
      end
      tmr_pkg::Y_HL: begin
        tick16[1] = y_src;
        reload16[1] = y_rise | y_fall;
      end
      default: tick16[1] = y_src;
    endcase
  end

  assign px_req = x_pol ? x_fall : x_rise;
  assign py_req = (y_mode == tmr_pkg::Y_PERIOD || y_mode == tmr_pkg::Y_HL) ?
    reload16[1] : (y_pol ? y_fall : y_rise);

  // ***************************************************************
  // 16-bit timers X and Y
  // ***************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_t16
    localparam logic [3:0] HI = (i == 0) ? tmr_pkg::IDX_TX_HI : tmr_pkg::IDX_TY_HI;
    localparam int WC = (i == 0) ? tmr_pkg::XM_WC : tmr_pkg::YM_WC;
    logic wc;
    assign wc = (i == 0) ? xmode_ff[WC] : ymode_ff[WC];
    assign direct16[i] = wr_take & (idx == HI) & ~wc;
    assign latchwr16[i] = wr_take & (idx == HI) & wc;
    assign uf16[i] = tick16[i] & (cnt16_ff[i] == 16'h0000) & ~direct16[i];

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt16_ff[i] <= tmr_pkg::CNT16_RST;
        latch16_ff[i] <= tmr_pkg::CNT16_RST;
      end else if (direct16[i]) begin
        cnt16_ff[i] <= {wdat, wr_buf_ff};
        latch16_ff[i] <= {wdat, wr_buf_ff};
      end else begin
        if (latchwr16[i]) begin
          latch16_ff[i] <= {wdat, wr_buf_ff};
        end
        if (reload16[i] | uf16[i]) begin
          cnt16_ff[i] <= latch16_ff[i];
        end else if (tick16[i]) begin
          cnt16_ff[i] <= cnt16_ff[i] - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_ff <= 16'h0000;
      hold_valid_ff <= 1'b0;
    end else if (reload16[1] & ~direct16[1]) begin
      hold_ff <= cnt16_ff[1];
      hold_valid_ff <= 1'b1;
    end else if (rd_fire && idx == tmr_pkg::IDX_TY_LO) begin
      hold_valid_ff <= 1'b0;
    end
  end
  assign y_val = hold_valid_ff ? hold_ff : cnt16_ff[1];

  // ***************************************************************
  // 8-bit timers 1, 2, 3
  // ***************************************************************
  for (genvar i = 0; i < 3; i++) begin : g_t8
    logic hit, lonly;
    assign tick8[i] = ticks.div_tick[smode_ff[2*i +: 2]];
    assign hit = wr_take & (idx == tmr_pkg::IDX_T1 + 4'(i));
    // shared control, timers 1 and 2
    assign lonly = (i < 2) & smode_ff[tmr_pkg::SM_WC12];
    assign direct8[i] = hit & ~lonly;
    assign latchwr8[i] = hit & lonly;
    assign uf8[i] = tick8[i] & (cnt8_ff[i] == 8'h00) & ~direct8[i];

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        cnt8_ff[i] <= tmr_pkg::CNT8_RST;
        latch8_ff[i] <= tmr_pkg::CNT8_RST;
      end else if (direct8[i]) begin
        cnt8_ff[i] <= wdat;
        latch8_ff[i] <= wdat;
      end else begin
        if (latchwr8[i]) begin
          latch8_ff[i] <= wdat;
        end
        if (uf8[i]) begin
          cnt8_ff[i] <= latch8_ff[i];
        end else if (tick8[i]) begin
          cnt8_ff[i] <= cnt8_ff[i] - 8'h01;
        end
      end
    end
  end

  // ***************************************************************
  // pin outputs
  // ***************************************************************
  logic y_out_en;
  assign y_out_en = (y_mode == tmr_pkg::Y_TIMER) & ymode_ff[tmr_pkg::YM_OUTEN];

  // idle level preset so the first underflow gives the first edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_x_ext_pin_o <= 1'b1;
      timer_x_ext_pin_oe <= 1'b0;
    end else begin
      timer_x_ext_pin_oe <= (x_mode == tmr_pkg::X_PULSE);
      // start level, taken again on the entering cycle
      if (x_mode != tmr_pkg::X_PULSE) begin
        timer_x_ext_pin_o <= ~x_pol;
      end else if (!timer_x_ext_pin_oe) begin
        timer_x_ext_pin_o <= uf16[0] ? x_pol : ~x_pol;
      end else if (uf16[0]) begin
        timer_x_ext_pin_o <= ~timer_x_ext_pin_o;
      end
    end
  end

  // toggle output, timer mode only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_y_ext_pin_o <= 1'b1;
      timer_y_ext_pin_oe <= 1'b0;
    end else begin
      timer_y_ext_pin_oe <= y_out_en;
      // start level, taken again on the entering cycle
      if (!y_out_en) begin
        timer_y_ext_pin_o <= ~y_pol;
      end else if (!timer_y_ext_pin_oe) begin
        timer_y_ext_pin_o <= uf16[1] ? y_pol : ~y_pol;
      end else if (uf16[1]) begin
        timer_y_ext_pin_o <= ~timer_y_ext_pin_o;
      end
    end
  end

  logic tog_on_ff;
  logic tog_uf;
  assign tog_uf = octl_ff[tmr_pkg::OC_SEL] ? uf8[1] : uf8[0];

  // selected timer toggles; enable and polarity may arrive together
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      small_timer_toggle_pin <= 1'b1;
      tog_on_ff <= 1'b0;
    end else begin
      tog_on_ff <= octl_ff[tmr_pkg::OC_EN];
      if (!octl_ff[tmr_pkg::OC_EN]) begin
        small_timer_toggle_pin <= ~octl_ff[tmr_pkg::OC_POL];
      end else if (!tog_on_ff) begin
        small_timer_toggle_pin <= tog_uf ? octl_ff[tmr_pkg::OC_POL] : ~octl_ff[tmr_pkg::OC_POL];
      end else if (tog_uf) begin
        small_timer_toggle_pin <= ~small_timer_toggle_pin;
      end
    end
  end

  // ***************************************************************
  // request flags and byte-pair buffers
  // ***************************************************************
  logic [7:0] st_set, st_clr;
  assign st_set = {1'b0, py_req, px_req, uf8, uf16};
  assign st_clr = (wr_take && idx == tmr_pkg::IDX_STATUS) ? wdat : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_ff <= 8'h00;
    end else begin
      status_ff <= (status_ff & ~st_clr) | st_set;
    end
  end

  // pairs rely on high-first reads, low-first writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_buf_ff <= 8'h00;
    end else if (wr_take && (idx == tmr_pkg::IDX_TX_LO || idx == tmr_pkg::IDX_TY_LO)) begin
      wr_buf_ff <= wdat;
    end
  end

  // read mux; high byte read freezes the low byte
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= 32'h0000_0000;
      rd_buf_ff <= 8'h00;
    end else if (rd_fire) begin
      rdata_ff <= 32'h0000_0000;
      if (idx == tmr_pkg::IDX_TX_HI) begin
        rdata_ff[7:0] <= cnt16_ff[0][15:8];
        rd_buf_ff <= cnt16_ff[0][7:0];
      end else if (idx == tmr_pkg::IDX_TY_HI) begin
        rdata_ff[7:0] <= y_val[15:8];
        rd_buf_ff <= y_val[7:0];
      end else if (idx == tmr_pkg::IDX_TX_LO || idx == tmr_pkg::IDX_TY_LO) begin
        rdata_ff[7:0] <= rd_buf_ff;
      end else if (idx >= tmr_pkg::IDX_T1 && idx < tmr_pkg::IDX_TX_MODE) begin
        rdata_ff[7:0] <= cnt8_ff[idx[1:0]];
      end else if (idx == tmr_pkg::IDX_TX_MODE) begin
        rdata_ff[7:0] <= xmode_ff;
      end else if (idx == tmr_pkg::IDX_TY_MODE) begin
        rdata_ff[7:0] <= ymode_ff;
      end else if (idx == tmr_pkg::IDX_T123_MODE) begin
        rdata_ff[7:0] <= smode_ff;
      end else if (idx == tmr_pkg::IDX_SMALL_TIMER_TOGGLE_PIN_CTRL) begin
        rdata_ff[7:0] <= octl_ff;
      end else if (idx == tmr_pkg::IDX_STATUS) begin
        rdata_ff[7:0] <= status_ff;
      end
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence y_edge_reload_s;
    reload16[1] && !direct16[1];
  endsequence
  sequence x_pulse_uf_s;
    x_mode == tmr_pkg::X_PULSE && timer_x_ext_pin_oe && uf16[0] &&
      !(wr_take && idx == tmr_pkg::IDX_TX_MODE);
  endsequence

  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("access not answered after one wait cycle");
  AST_X_PULSE_TOGGLE: assert property (x_pulse_uf_s |=> timer_x_ext_pin_o != $past(timer_x_ext_pin_o))
    else $error("pulse output did not invert on underflow");
  AST_X_UF_RELOAD: assert property (uf16[0] && !reload16[0] |=> cnt16_ff[0] == $past(latch16_ff[0]))
    else $error("timer X did not reload on underflow");
  AST_X_STOP: assert property (xmode_ff[tmr_pkg::XM_STOP] && !direct16[0] |=> $stable(cnt16_ff[0]))
    else $error("timer X counted while stopped");
  AST_X_DIRECT: assert property (direct16[0] |=> cnt16_ff[0] == latch16_ff[0])
    else $error("direct write did not load counter and latch");
  AST_X_LATCH_ONLY: assert property (latchwr16[0] && !tick16[0] |=> $stable(cnt16_ff[0]))
    else $error("latch-only write disturbed the counter");
  AST_Y_CAPTURE: assert property (y_edge_reload_s |=> hold_valid_ff && hold_ff == $past(cnt16_ff[1]))
    else $error("pre-reload value not captured");
  AST_Y_EDGE_REQ: assert property (y_edge_reload_s |=> status_ff[tmr_pkg::ST_PY] ##0 cnt16_ff[1] == $past(latch16_ff[1]))
    else $error("edge reload did not raise request and reload");
  AST_Y_NO_TOGGLE: assert property (y_mode == tmr_pkg::Y_EVENT ##1 y_mode == tmr_pkg::Y_EVENT |-> !timer_y_ext_pin_oe)
    else $error("toggle output active in event mode");
  AST_T1_RELOAD: assert property (uf8[0] |=> cnt8_ff[0] == $past(latch8_ff[0]) ##0 status_ff[tmr_pkg::ST_T1])
    else $error("timer 1 underflow not handled");
endmodule
`default_nettype wire

/* File: design/pin_sampler.sv */
/*
  Two-flop synchroniser with edge detection for one external pin.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sampler (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // meta_ff feeds only sync_ff
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges seen on the synchronised copy only
  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

/* File: design/tick_divider.sv */
/*
  Free-running prescaler giving one-cycle enables at sys_clk/8,16,32,64.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
  input wire logic sys_clk,
  input wire logic rst_b,
  tick_if.src ticks
);
  logic [tmr_pkg::DIV_W-1:0] cnt_ff;
  logic [3:0] tick_ff;
  logic [3:0] nxt_tick;

  // free counter, never stopped so phases stay fixed
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // one tap per divide ratio
  for (genvar k = 0; k < tmr_pkg::DIV_TAPS; k++) begin : g_tap
    assign nxt_tick[k] = &cnt_ff[k+tmr_pkg::DIV_FIRST-1:0];
  end

  // registered so the enables are glitch free
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 4'h0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign ticks.div_tick = tick_ff;
endmodule
`default_nettype wire

/* File: verification/multi_mode_timer_set_test.sv */
/*
  Self-checking bench for the timer set: bus tasks, one task per case.
  Assumes the pin_env partner and a one-wait-state Avalon-MM slave.
*/
`timescale 1ns/1ps
`default_nettype none
module multi_mode_timer_set_test;
  logic sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic x_o, x_oe, y_o, y_oe, x_pin, y_pin, x_lvl, y_lvl, scs_run, scs_clk, tog;
  logic [15:0] v, w;
  logic [7:0] q;
  int mismatches, comparisons;
  // ****************************************
  // instances and clock
  // ****************************************
  multi_mode_timer_set u_multi_mode_timer_set (.sys_clk(sys_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_x_ext_pin_i(x_pin), .timer_x_ext_pin_o(x_o),
    .timer_x_ext_pin_oe(x_oe), .timer_y_ext_pin_i(y_pin), .timer_y_ext_pin_o(y_o),
    .timer_y_ext_pin_oe(y_oe), .small_timer_toggle_pin(tog),
    .special_count_source_clock(scs_clk));
  pin_env u_pin_env (.sys_clk(sys_clk), .x_oe(x_oe), .x_o(x_o), .x_lvl(x_lvl),
    .y_oe(y_oe), .y_o(y_o), .y_lvl(y_lvl), .scs_run(scs_run), .x_pin(x_pin),
    .y_pin(y_pin), .scs_clk(scs_clk));
  // 20 MHz
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic ok);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: unexpected value", $time);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > 20) begin
        mismatches++;
        final_report();
      end
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [3:0] idx, output logic [7:0] r);
    bus(1'b0, idx, 8'h00, r);
  endtask
  // high byte read first, low byte written first
  task automatic rd16(input logic [3:0] lo, output logic [15:0] r);
    rd(lo + 4'h1, r[15:8]);
    rd(lo, r[7:0]);
  endtask
  task automatic wr16(input logic [3:0] lo, input logic [15:0] d);
    wr(lo, d[7:0]);
    wr(lo + 4'h1, d[15:8]);
  endtask
  // polls the sticky status; bounded so a dead timer cannot hang the run
  task automatic wait_st(input int b);
    logic [7:0] s;
    comparisons++;
    for (int n = 0; n < 1000; n++) begin
      rd(tmr_pkg::IDX_STATUS, s);
      if (s[b] === 1'b1) return;
    end
    mismatches++;
    $display("CHECK FAILED at %0t: status bit never set", $time);
    final_report();
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v[15:8] === 8'hFF);
    rd(tmr_pkg::IDX_T1, q);
    chk(q[7:4] === 4'hF);
    rd(4'hC, q);
    chk(q === 8'h00 && x_oe === 1'b0 && tog === 1'b1);
  endtask
  task automatic t_xwc();
    wr(tmr_pkg::IDX_TX_MODE, 8'h00);
    wr16(tmr_pkg::IDX_TX_LO, 16'h0003);
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v <= 16'h0003);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_TX);
    wr(tmr_pkg::IDX_TX_MODE, 8'h80);
    wr16(tmr_pkg::IDX_TX_LO, 16'h0040);
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v <= 16'h0003);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_TX);
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v > 16'h0003 && v <= 16'h0040);
    wr(tmr_pkg::IDX_TX_MODE, 8'h40);
    rd16(tmr_pkg::IDX_TX_LO, v);
    repeat (100) @(posedge sys_clk);
    rd16(tmr_pkg::IDX_TX_LO, w);
    chk(v === w);
    wr(tmr_pkg::IDX_TX_MODE, 8'h10);
    rd16(tmr_pkg::IDX_TX_LO, v);
    repeat (100) @(posedge sys_clk);
    rd16(tmr_pkg::IDX_TX_LO, w);
    chk(v === w);
    scs_run <= 1'b1;
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_TX);
    scs_run <= 1'b0;
  endtask
  task automatic t_xpulse();
    wr(tmr_pkg::IDX_TX_MODE, 8'h61);
    repeat (2) @(posedge sys_clk);
    chk(x_oe === 1'b1 && x_o === 1'b0);
    wr(tmr_pkg::IDX_TX_MODE, 8'h21);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_TX);
    chk(x_o === 1'b1);
  endtask
  task automatic t_xevent();
    wr(tmr_pkg::IDX_TX_MODE, 8'h02);
    wr16(tmr_pkg::IDX_TX_LO, 16'h0005);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    // two full pulses, each level held well past the synchroniser
    repeat (2) begin
      x_lvl <= 1'b1;
      repeat (6) @(posedge sys_clk);
      x_lvl <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v === 16'h0003);
    rd(tmr_pkg::IDX_STATUS, q);
    chk(q[tmr_pkg::ST_PX] === 1'b1);
    wr(tmr_pkg::IDX_TX_MODE, 8'h03);
    wr16(tmr_pkg::IDX_TX_LO, 16'h0100);
    repeat (100) @(posedge sys_clk);
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v === 16'h0100);
    x_lvl <= 1'b1;
    repeat (100) @(posedge sys_clk);
    rd16(tmr_pkg::IDX_TX_LO, v);
    chk(v < 16'h0100 && v > 16'h00F0);
    x_lvl <= 1'b0;
  endtask
  task automatic t_yperiod();
    wr(tmr_pkg::IDX_TY_MODE, 8'h01);
    wr16(tmr_pkg::IDX_TY_LO, 16'h0100);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    y_lvl <= 1'b1;
    repeat (100) @(posedge sys_clk);
    rd(tmr_pkg::IDX_STATUS, q);
    chk(q[tmr_pkg::ST_PY] === 1'b0 && y_oe === 1'b0);
    y_lvl <= 1'b0;
    wait_st(tmr_pkg::ST_PY);
    rd16(tmr_pkg::IDX_TY_LO, v);
    rd16(tmr_pkg::IDX_TY_LO, w);
    chk(v < 16'h0100 && v > 16'h00E0 && w > v);
  endtask
  task automatic t_ytoggle();
    wr(tmr_pkg::IDX_TY_MODE, 8'h30);
    repeat (2) @(posedge sys_clk);
    chk(y_oe === 1'b1 && y_o === 1'b0);
    wr16(tmr_pkg::IDX_TY_LO, 16'h0003);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_TY);
    chk(y_o === 1'b1);
  endtask
  task automatic t_tog();
    wr(tmr_pkg::IDX_T123_MODE, 8'h03);
    wr(tmr_pkg::IDX_T1, 8'h10);
    wr(tmr_pkg::IDX_T1 + 4'h1, 8'hFF);
    wr(tmr_pkg::IDX_T1 + 4'h2, 8'hFF);
    wr(tmr_pkg::IDX_SMALL_TIMER_TOGGLE_PIN_CTRL, 8'h05);
    repeat (2) @(posedge sys_clk);
    chk(tog === 1'b0);
    wr(tmr_pkg::IDX_T123_MODE, 8'h43);
    wr(tmr_pkg::IDX_T1, 8'h05);
    rd(tmr_pkg::IDX_T1, q);
    chk(q > 8'h05);
    wr(tmr_pkg::IDX_STATUS, 8'hFF);
    wait_st(tmr_pkg::ST_T1);
    chk(tog === 1'b1);
    rd(tmr_pkg::IDX_T1, q);
    chk(q <= 8'h05);
  endtask
  // reset held 20 cycles, then the cases in turn
  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    x_lvl = 1'b0;
    y_lvl = 1'b0;
    scs_run = 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_xwc();
    t_xpulse();
    t_xevent();
    t_yperiod();
    t_ytoggle();
    t_tog();
    final_report();
  end
endmodule
`default_nettype wire

/* File: verification/pin_env.sv */
/*
  Pin-side partner: level sources for both timer pins and the special
  count clock. Assumes the bench sets levels right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_env (
  input wire logic sys_clk,
  input wire logic x_oe,
  input wire logic x_o,
  input wire logic x_lvl,
  input wire logic y_oe,
  input wire logic y_o,
  input wire logic y_lvl,
  input wire logic scs_run,
  output logic x_pin,
  output logic y_pin,
  output var logic scs_clk
);
  // ****************************************
  // pin resolution and count clock
  // ****************************************
  // a driven pin shows the device level, else the outside source
  assign x_pin = x_oe ? x_o : x_lvl;
  assign y_pin = y_oe ? y_o : y_lvl;
  // clock stands still at low outside bursts, so no stray pulses
  always_ff @(posedge sys_clk) begin
    scs_clk <= scs_run ? ~scs_clk : 1'b0;
  end
endmodule
`default_nettype wire
